// File: include/dctg_pkg.sv
// dctg_pkg: shared types and timing constants of the DRAM cycle timing generator.
// Assumes one memory clock; every interval is counted in half memory clocks.
// Function
// RULE1 - a random read or write cycle lasts five, four or three clocks for cycle length 00, 01, 10; code stretches cycles to fit strobes, never under four.
// RULE2 - during access cycles the row strobe stays high for precharge about 2, 1.45 or 1 clocks.
// RULE3 - row-to-column delay is 1.5/2.5 clocks (bit set/clear) for field 00 or 10, 1/2 for 01.
// RULE4 - the row address leads the row strobe by 2, 1.45 or 1 clocks and is held 1 or 0.45 clock.
// RULE5 - read data is sampled no earlier than the row-strobe access time for the setting in force.
// RULE6 - refresh drops the column strobe before the row strobe, leading by about half a clock.
// RULE7 - before a refresh the column strobe stays high two clocks for field 00, else one clock.
// RULE8 - in page-mode refresh, row rise to column fall is two clocks for 00, one for 01 or 10.
// RULE9 - in EDO refresh, row rise to column fall is 1.45 clocks for 00 and 0.45 for 01 or 10.
// RULE10 - in EDO refresh the column strobe leads by half a clock for 00 or 10, a full one for 01.
// RULE11 - in page-mode refresh the row strobe precharges about 2.45 clocks for 00, else 1.45.
// RULE12 - in a read-write cycle the data driver turns on half a clock after the write strobe.
// RULE13 - fractional placements come from sequencing on both clock edges from config counters.
package dctg_pkg;
  localparam int ROW_W = 10;
  localparam int DATA_W = 16;
  localparam int BE_W = 2;
  localparam int HT_W = 6;
  localparam int CYC_W = 5;
  localparam int STB_W = 5;
  // strobe vector lanes
  localparam int STB_RAS = 0;
  localparam int STB_CAS0 = 1;
  localparam int STB_CAS1 = 2;
  localparam int STB_WE = 3;
  localparam int STB_OE = 4;
  // field encodings; code 11 is treated as the slowest setting
  localparam logic [1:0] PRE_MID = 2'h1;
  localparam logic [1:0] PRE_SHORT = 2'h2;
  localparam logic [1:0] LEN_4 = 2'h1;
  localparam logic [1:0] LEN_3 = 2'h2;
  // cycle lengths in half clocks
  localparam logic [HT_W-1:0] LEN_5_H = 6'h0a;
  localparam logic [HT_W-1:0] LEN_4_H = 6'h08;
  localparam logic [HT_W-1:0] LEN_3_H = 6'h06;
  // access timing in half clocks (x.45 clocks rounded up to x.5)
  localparam logic [HT_W-1:0] RAS_SET_00_H = 6'h04;
  localparam logic [HT_W-1:0] RAS_SET_01_H = 6'h03;
  localparam logic [HT_W-1:0] RAS_SET_10_H = 6'h02;
  localparam logic [HT_W-1:0] ROW_HOLD_H = 6'h02;
  localparam logic [HT_W-1:0] ROW_HOLD_01_H = 6'h01;
  localparam logic [HT_W-1:0] RCD_SET_H = 6'h03;
  localparam logic [HT_W-1:0] RCD_CLR_H = 6'h05;
  localparam logic [HT_W-1:0] RCD01_SET_H = 6'h02;
  localparam logic [HT_W-1:0] RCD01_CLR_H = 6'h04;
  localparam logic [HT_W-1:0] ACC_EXTRA_H = 6'h01;
  localparam logic [HT_W-1:0] CAS_PULSE_H = 6'h01;
  localparam logic [HT_W-1:0] WE_LEAD_H = 6'h01;
  localparam logic [HT_W-1:0] WE_TRAIL_H = 6'h01;
  localparam logic [HT_W-1:0] OE_DELAY_H = 6'h01;
  localparam logic [HT_W-1:0] RMW_WRITE_H = 6'h03;
  localparam logic [HT_W-1:0] RAS_HOLD_H = 6'h01;
  // refresh timing in half clocks
  localparam logic [HT_W-1:0] CAS_PRE_00_H = 6'h04;
  localparam logic [HT_W-1:0] CAS_PRE_H = 6'h02;
  localparam logic [HT_W-1:0] CBR_LEAD_H = 6'h01;
  localparam logic [HT_W-1:0] CBR_LEAD_EDO01_H = 6'h02;
  localparam logic [HT_W-1:0] CBR_LOW_H = 6'h02;
  localparam logic [HT_W-1:0] FPM_RP_00_H = 6'h05;
  localparam logic [HT_W-1:0] FPM_RP_H = 6'h03;
  localparam logic [HT_W-1:0] EDO_RP_00_H = 6'h04;
  localparam logic [HT_W-1:0] EDO_RP_01_H = 6'h03;
  localparam logic [HT_W-1:0] EDO_RP_10_H = 6'h02;
  localparam logic [HT_W-1:0] FPM_RC_00_H = 6'h04;
  localparam logic [HT_W-1:0] FPM_RC_H = 6'h02;
  localparam logic [HT_W-1:0] EDO_RC_00_H = 6'h03;
  localparam logic [HT_W-1:0] EDO_RC_H = 6'h01;

  typedef enum logic [2:0] {
    DCTG_READ,
    DCTG_WRITE,
    DCTG_RMW,
    DCTG_REFRESH,
    DCTG_SELF
  } dctg_kind_type;

  typedef enum logic [1:0] {
    DCTG_IDLE,
    DCTG_RUN,
    DCTG_HOLD
  } dctg_state_type;

  typedef struct packed {
    logic edo;
    logic [1:0] cycle_length_field;
    logic row_column_delay_bit;
    logic [1:0] precharge_setup_field;
  } dctg_cfg_type;

  typedef struct packed {
    dctg_kind_type kind;
    logic [ROW_W-1:0] row;
    logic [ROW_W-1:0] col;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0] byte_en;
  } dctg_req_type;
endpackage

// File: hdl/dctg_dual_edge.sv
// dctg_dual_edge: strobe levels that may change on both edges of the memory clock.
// Assumes both half-cycle levels are presented before each rising edge.
`timescale 1ns/1ps
module dctg_dual_edge #(
  parameter int W = 1
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [W-1:0] first_i,
  input wire logic [W-1:0] second_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] rise_q;
  logic [W-1:0] sec_q;
  logic [W-1:0] fall_q;
  logic ce_q;

  // xor pairing keeps each output a plain flop-to-flop path, no clock in the data path
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rise_q <= '0;
      sec_q <= '0;
      ce_q <= 1'b0;
    end
    else
    begin
      ce_q <= ce_i;
      if (ce_i)
      begin
        rise_q <= first_i ^ fall_q;
        sec_q <= second_i;
      end
    end
  end

  // falling half follows the enable seen at the preceding rising edge
  always_ff @(negedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      fall_q <= '0;
    else if (ce_q)
      fall_q <= sec_q ^ rise_q;
  end

  assign level_o = rise_q ^ fall_q;
endmodule

// File: hdl/dctg_top.sv
// dctg_top: sequencer for row, column and write strobes of 16-bit EDO or page-mode DRAM.
// Assumes the host holds a request until taken and the DRAM inputs are synchronous.
`timescale 1ns/1ps
module dctg_top (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire dctg_pkg::dctg_cfg_type cfg_i,
  input wire logic req_valid_i,
  input wire dctg_pkg::dctg_req_type req_i,
  input wire logic selfref_hold_i,
  input wire logic [dctg_pkg::DATA_W-1:0] dq_i,
  output logic req_ready_o,
  output logic busy_o,
  output logic [dctg_pkg::DATA_W-1:0] rdata_o,
  output logic rdata_valid_o,
  output logic ras_b_o,
  output logic [dctg_pkg::BE_W-1:0] cas_b_o,
  output logic we_b_o,
  output logic [dctg_pkg::ROW_W-1:0] ma_o,
  output logic [dctg_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o
);
  logic rst_meta_q;
  logic rst_q;
  dctg_pkg::dctg_state_type state_q;
  dctg_pkg::dctg_state_type state_d;
  logic [dctg_pkg::CYC_W-1:0] cyc_q;
  logic [dctg_pkg::CYC_W-1:0] cyc_d;
  logic [dctg_pkg::CYC_W-1:0] cnt_q;
  dctg_pkg::dctg_req_type req_q;
  dctg_pkg::dctg_cfg_type cfg_q;
  logic [dctg_pkg::ROW_W-1:0] ma_q;
  logic [dctg_pkg::ROW_W-1:0] ma_d;
  logic [dctg_pkg::DATA_W-1:0] dq_q;
  logic [dctg_pkg::DATA_W-1:0] rdata_q;
  logic rvalid_q;
  logic [dctg_pkg::STB_W-1:0] act0;
  logic [dctg_pkg::STB_W-1:0] act1;
  logic [dctg_pkg::STB_W-1:0] lvl;

  function automatic logic in_win(input logic [dctg_pkg::HT_W-1:0] t,
                                  input logic [dctg_pkg::HT_W-1:0] f,
                                  input logic [dctg_pkg::HT_W-1:0] r);
    in_win = (t >= f) && (t < r);
  endfunction

  // reset release through two flops; only the second one is used
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end

  // request decode
  wire run = (state_q != dctg_pkg::DCTG_IDLE);
  wire accept = ce_i && rst_q && (state_q == dctg_pkg::DCTG_IDLE) && req_valid_i;
  wire is_ref = (req_q.kind == dctg_pkg::DCTG_REFRESH) || (req_q.kind == dctg_pkg::DCTG_SELF);
  wire is_rmw = (req_q.kind == dctg_pkg::DCTG_RMW);
  wire is_wr = (req_q.kind == dctg_pkg::DCTG_WRITE);
  wire is_rd = (req_q.kind == dctg_pkg::DCTG_READ) || is_rmw;
  wire pre_mid = (cfg_q.precharge_setup_field == dctg_pkg::PRE_MID);
  wire pre_short = (cfg_q.precharge_setup_field == dctg_pkg::PRE_SHORT);
  wire pre_long = !pre_mid && !pre_short;
  wire rcd_bit = cfg_q.row_column_delay_bit;
  wire [dctg_pkg::HT_W-1:0] t0 = {cyc_q, 1'b0};
  wire [dctg_pkg::HT_W-1:0] t1 = {cyc_q, 1'b1};

  // access placement: row strobe falls after the row precharge/address setup
  wire [dctg_pkg::HT_W-1:0] ras_set_h = pre_mid ? dctg_pkg::RAS_SET_01_H :
    pre_short ? dctg_pkg::RAS_SET_10_H : dctg_pkg::RAS_SET_00_H; // see RULE2 see RULE4
  wire [dctg_pkg::HT_W-1:0] row_hold_h = pre_mid ? dctg_pkg::ROW_HOLD_01_H :
    dctg_pkg::ROW_HOLD_H; // see RULE4
  wire [dctg_pkg::HT_W-1:0] rcd_h = pre_mid ?
    (rcd_bit ? dctg_pkg::RCD01_SET_H : dctg_pkg::RCD01_CLR_H) :
    (rcd_bit ? dctg_pkg::RCD_SET_H : dctg_pkg::RCD_CLR_H); // see RULE3
  wire [dctg_pkg::HT_W-1:0] a_cas_fall = ras_set_h + rcd_h;
  // read data is only caught on a rising edge, so the access time rounds up
  wire [dctg_pkg::HT_W-1:0] samp_raw = a_cas_fall + dctg_pkg::ACC_EXTRA_H;
  wire [dctg_pkg::HT_W-1:0] samp_h = samp_raw + {5'h00, samp_raw[0]}; // see RULE5
  wire [dctg_pkg::HT_W-1:0] a_cas_rise = is_rmw ? samp_h + dctg_pkg::RMW_WRITE_H :
    a_cas_fall + dctg_pkg::CAS_PULSE_H;
  wire [dctg_pkg::HT_W-1:0] we_fall_h = is_rmw ? samp_h : a_cas_fall - dctg_pkg::WE_LEAD_H;
  wire [dctg_pkg::HT_W-1:0] we_rise_h = a_cas_rise + dctg_pkg::WE_TRAIL_H;
  wire [dctg_pkg::HT_W-1:0] oe_on_h = is_rmw ? samp_h + dctg_pkg::OE_DELAY_H :
    we_fall_h; // see RULE12

  // refresh placement: column precharge, column leads row, then recovery
  wire [dctg_pkg::HT_W-1:0] r_cas_fall = pre_long ? dctg_pkg::CAS_PRE_00_H :
    dctg_pkg::CAS_PRE_H; // see RULE7
  wire [dctg_pkg::HT_W-1:0] lead_h = (cfg_q.edo && pre_mid) ? dctg_pkg::CBR_LEAD_EDO01_H :
    dctg_pkg::CBR_LEAD_H; // see RULE6 see RULE10
  wire [dctg_pkg::HT_W-1:0] r_ras_fall = r_cas_fall + lead_h;
  wire [dctg_pkg::HT_W-1:0] r_rise = r_ras_fall + dctg_pkg::CBR_LOW_H;
  wire [dctg_pkg::HT_W-1:0] rp_h = !cfg_q.edo ?
    (pre_long ? dctg_pkg::FPM_RP_00_H : dctg_pkg::FPM_RP_H) :
    (pre_long ? dctg_pkg::EDO_RP_00_H :
    pre_mid ? dctg_pkg::EDO_RP_01_H : dctg_pkg::EDO_RP_10_H); // see RULE11
  wire [dctg_pkg::HT_W-1:0] rc_h = !cfg_q.edo ?
    (pre_long ? dctg_pkg::FPM_RC_00_H : dctg_pkg::FPM_RC_H) : // see RULE8
    (pre_long ? dctg_pkg::EDO_RC_00_H : dctg_pkg::EDO_RC_H); // see RULE9
  wire [dctg_pkg::HT_W-1:0] rec_h = (rp_h > rc_h) ? rp_h : rc_h;

  // merged schedule of the running cycle
  wire [dctg_pkg::HT_W-1:0] ras_fall_h = is_ref ? r_ras_fall : ras_set_h;
  wire [dctg_pkg::HT_W-1:0] ras_rise_h = is_ref ? r_rise : a_cas_rise + dctg_pkg::RAS_HOLD_H;
  wire [dctg_pkg::HT_W-1:0] cas_fall_h = is_ref ? r_cas_fall : a_cas_fall;
  wire [dctg_pkg::HT_W-1:0] cas_rise_h = is_ref ? r_rise : a_cas_rise;
  wire [dctg_pkg::HT_W-1:0] tail_h = is_ref ? ras_rise_h + rec_h : ras_rise_h;
  wire [dctg_pkg::HT_W-1:0] need_h = tail_h + {5'h00, tail_h[0]};
  wire [dctg_pkg::HT_W-1:0] len_h =
    (cfg_q.cycle_length_field == dctg_pkg::LEN_4) ? dctg_pkg::LEN_4_H :
    (cfg_q.cycle_length_field == dctg_pkg::LEN_3) ? dctg_pkg::LEN_3_H : dctg_pkg::LEN_5_H;
  // a cycle never ends before its strobes are done, even if the length field is shorter
  wire [dctg_pkg::HT_W-1:0] end_h = (len_h > need_h) ? len_h : need_h; // see RULE1
  wire [dctg_pkg::CYC_W-1:0] last_cyc = end_h[dctg_pkg::HT_W-1:1] - 5'h01;

  // self refresh parks with both strobes low while the hold request stays up
  wire self_hold = (state_q == dctg_pkg::DCTG_HOLD) ||
    ((state_q == dctg_pkg::DCTG_RUN) && (req_q.kind == dctg_pkg::DCTG_SELF) &&
    selfref_hold_i && (t0 >= ras_fall_h));
  wire done = (state_q == dctg_pkg::DCTG_RUN) && !self_hold && (cyc_q == last_cyc);
  wire sample = (state_q == dctg_pkg::DCTG_RUN) && is_rd && !is_ref && (t0 == samp_h);
  wire col_sel = run && !is_ref && (t0 >= ras_set_h + row_hold_h); // see RULE4

  // strobe activity for both halves of the cycle named by cyc_q
  wire ras_a0 = run && (self_hold || in_win(t0, ras_fall_h, ras_rise_h));
  wire ras_a1 = run && (self_hold || in_win(t1, ras_fall_h, ras_rise_h));
  wire cas_a0 = run && (self_hold || in_win(t0, cas_fall_h, cas_rise_h)); // see RULE6
  wire cas_a1 = run && (self_hold || in_win(t1, cas_fall_h, cas_rise_h));
  wire [dctg_pkg::BE_W-1:0] cas_be = is_ref ? 2'h3 : req_q.byte_en;
  wire wr_any = run && !is_ref && (is_wr || is_rmw);
  wire we_a0 = wr_any && in_win(t0, we_fall_h, we_rise_h);
  wire we_a1 = wr_any && in_win(t1, we_fall_h, we_rise_h);
  wire oe_a0 = wr_any && in_win(t0, oe_on_h, we_rise_h);
  wire oe_a1 = wr_any && in_win(t1, oe_on_h, we_rise_h); // see RULE12
  assign act0 = {oe_a0, we_a0, cas_a0 & cas_be[1], cas_a0 & cas_be[0], ras_a0};
  assign act1 = {oe_a1, we_a1, cas_a1 & cas_be[1], cas_a1 & cas_be[0], ras_a1};

  // half-clock placement on both edges of the memory clock
  dctg_dual_edge #(
    .W(dctg_pkg::STB_W)
  ) u_strobes (
    .clock_i(clock_i),
    .rst_b_i(rst_q),
    .ce_i(ce_i),
    .first_i(act0),
    .second_i(act1),
    .level_o(lvl)
  ); // see RULE13

  // sequencer next state
  always_comb
  begin
    state_d = state_q;
    cyc_d = cyc_q;
    case (state_q)
      dctg_pkg::DCTG_IDLE:
      begin
        if (accept)
        begin
          state_d = dctg_pkg::DCTG_RUN;
          cyc_d = '0;
        end
      end
      dctg_pkg::DCTG_RUN:
      begin
        if (self_hold)
          state_d = dctg_pkg::DCTG_HOLD;
        else if (cyc_q == last_cyc)
        begin
          state_d = dctg_pkg::DCTG_IDLE;
          cyc_d = '0;
        end
        else
          cyc_d = cyc_q + 5'h01; // see RULE13
      end
      dctg_pkg::DCTG_HOLD:
      begin
        if (!selfref_hold_i)
        begin
          state_d = dctg_pkg::DCTG_RUN;
          cyc_d = cyc_q + 5'h01;
        end
      end
      default: state_d = dctg_pkg::DCTG_IDLE;
    endcase
  end

  assign ma_d = accept ? req_i.row : (col_sel ? req_q.col : ma_q);

  // sequencer state and cycle counter
  always_ff @(posedge clock_i or negedge rst_q)
  begin
    if (!rst_q)
    begin
      state_q <= dctg_pkg::DCTG_IDLE;
      cyc_q <= '0;
      cnt_q <= '0;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      cnt_q <= accept ? 5'h00 : cnt_q + {4'h0, run};
    end
  end

  // request capture; config is frozen per cycle so mid-cycle writes cannot tear timing
  always_ff @(posedge clock_i or negedge rst_q)
  begin
    if (!rst_q)
    begin
      req_q <= '0;
      cfg_q <= '0;
      dq_q <= '0;
    end
    else if (ce_i && accept)
    begin
      req_q <= req_i;
      cfg_q <= cfg_i;
      dq_q <= req_i.wdata;
    end
  end

  // address mux and read capture
  always_ff @(posedge clock_i or negedge rst_q)
  begin
    if (!rst_q)
    begin
      ma_q <= '0;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end
    else if (ce_i)
    begin
      ma_q <= ma_d;
      rvalid_q <= sample; // see RULE5
      if (sample)
        rdata_q <= dq_i;
    end
  end

  assign req_ready_o = rst_q && (state_q == dctg_pkg::DCTG_IDLE);
  assign busy_o = run;
  assign rdata_o = rdata_q;
  assign rdata_valid_o = rvalid_q;
  assign ras_b_o = ~lvl[dctg_pkg::STB_RAS];
  assign cas_b_o = ~lvl[dctg_pkg::STB_CAS1:dctg_pkg::STB_CAS0];
  assign we_b_o = ~lvl[dctg_pkg::STB_WE];
  assign dq_oe_o = lvl[dctg_pkg::STB_OE];
  assign ma_o = ma_q;
  assign dq_o = dq_q;

  property p_cycle_len;
    @(posedge clock_i) disable iff (!rst_q)
    (ce_i && done && !is_ref) |-> (cnt_q + 5'h01 >= ((cfg_q.cycle_length_field == 2'h1) ? 5'h04 :
      (cfg_q.cycle_length_field == 2'h2) ? 5'h03 : 5'h05));
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("cycle shorter than length field"); // RULE1

  property p_ras_precharge;
    @(posedge clock_i) disable iff (!rst_q)
    (accept && (req_i.kind == dctg_pkg::DCTG_READ) && (cfg_i.precharge_setup_field == 2'h0))
      |=> ras_b_o [*3];
  endproperty
  a_ras_precharge: assert property (p_ras_precharge) else $error("row precharge too short"); // RULE2

  property p_rcd;
    @(posedge clock_i) disable iff (!rst_q)
    (run && !is_ref) |-> (cas_fall_h - ras_fall_h == (pre_mid ? (rcd_bit ? 6'h02 : 6'h04) :
      (rcd_bit ? 6'h03 : 6'h05)));
  endproperty
  a_rcd: assert property (p_rcd) else $error("row to column delay wrong"); // RULE3

  property p_row_hold;
    @(posedge clock_i) disable iff (!rst_q)
    (ce_i && run && !is_ref && (t0 <= ras_fall_h)) |=> (ma_o == req_q.row);
  endproperty
  a_row_hold: assert property (p_row_hold) else $error("row address not held"); // RULE4

  property p_sample;
    @(posedge clock_i) disable iff (!rst_q)
    rdata_valid_o |-> ({$past(cyc_q), 1'b0} >= $past(ras_fall_h) + $past(rcd_h) + 6'h01);
  endproperty
  a_sample: assert property (p_sample) else $error("read data sampled too early"); // RULE5

  property p_cbr_order;
    @(posedge clock_i) disable iff (!rst_q)
    (run && is_ref && ras_a0) |-> cas_a0;
  endproperty
  a_cbr_order: assert property (p_cbr_order) else $error("row strobe before column"); // RULE6

  property p_cas_pre;
    @(posedge clock_i) disable iff (!rst_q)
    (accept && (req_i.kind == dctg_pkg::DCTG_REFRESH) && (cfg_i.precharge_setup_field == 2'h0))
      |=> (cas_b_o == 2'h3) [*3];
  endproperty
  a_cas_pre: assert property (p_cas_pre) else $error("column precharge too short"); // RULE7

  property p_fpm_rc;
    @(posedge clock_i) disable iff (!rst_q)
    (done && is_ref && !cfg_q.edo) |-> (end_h >= ras_rise_h + (pre_long ? 6'h04 : 6'h02));
  endproperty
  a_fpm_rc: assert property (p_fpm_rc) else $error("page refresh recovery short"); // RULE8

  property p_edo_rc;
    @(posedge clock_i) disable iff (!rst_q)
    (done && is_ref && cfg_q.edo) |-> (end_h >= ras_rise_h + (pre_long ? 6'h03 : 6'h01));
  endproperty
  a_edo_rc: assert property (p_edo_rc) else $error("edo refresh recovery short"); // RULE9

  property p_edo_lead;
    @(posedge clock_i) disable iff (!rst_q)
    (run && is_ref && cfg_q.edo) |-> (ras_fall_h - cas_fall_h == (pre_mid ? 6'h02 : 6'h01));
  endproperty
  a_edo_lead: assert property (p_edo_lead) else $error("edo column lead wrong"); // RULE10

  property p_fpm_rp;
    @(posedge clock_i) disable iff (!rst_q)
    (done && is_ref && !cfg_q.edo) |-> (end_h >= ras_rise_h + (pre_long ? 6'h05 : 6'h03));
  endproperty
  a_fpm_rp: assert property (p_fpm_rp) else $error("page refresh precharge short"); // RULE11

  property p_oe_delay;
    @(posedge clock_i) disable iff (!rst_q)
    (run && is_rmw && (t0 == we_fall_h)) |-> !oe_a0 && oe_a1;
  endproperty
  a_oe_delay: assert property (p_oe_delay) else $error("driver not half after write"); // RULE12
endmodule

// File: dv/dctg_dram_model.sv
// dctg_dram_model: behavioural page-mode or EDO DRAM, 16 words picked by low column bits.
// Assumes active-low strobes; after a rise of column strobe 0 the data line toggles, never holds.
`timescale 1ns/1ps
module dctg_dram_model (
  input wire logic ras_b_i,
  input wire logic [1:0] cas_b_i,
  input wire logic we_b_i,
  input wire logic [9:0] ma_i,
  input wire logic [15:0] wd_i,
  input wire logic oe_i,
  output logic [15:0] dq_o
);
  logic [15:0] mem [16];
  logic [3:0] col_q;
  // column taken at strobe fall; read word shows after a short access delay
  always @(negedge cas_b_i[0])
  begin
    col_q = ma_i[3:0];
    if (!ras_b_i && we_b_i)
      dq_o <= #1 mem[ma_i[3:0]];
  end
  // late write at strobe rise, so the driver must still be on then
  always @(posedge cas_b_i[0])
  begin
    if (!ras_b_i && !we_b_i && oe_i)
      mem[col_q] = wd_i;
    dq_o <= #2 ~dq_o;  // inverted 2 ns after the strobe rises
  end
  initial
  begin
    dq_o = 16'h0;
    for (int i = 0; i < 16; i++)
      mem[i] = 16'h0;
  end
endmodule

// File: dv/tb_dctg_top.sv
// tb_dctg_top: self-checking bench for the DRAM strobe sequencer.
// Assumes the behavioural DRAM model on the strobe side; strobe edges are timed in ns.
`timescale 1ns/1ps
module tb_dctg_top;
  logic clock_i;
  logic rst_b_i;
  logic ce_i;
  logic req_valid_i;
  logic selfref_hold_i;
  dctg_pkg::dctg_cfg_type cfg_i;
  dctg_pkg::dctg_req_type req_i;
  logic [15:0] dq_i;
  logic [15:0] rdata_o;
  logic [15:0] dq_o;
  logic [9:0] ma_o;
  logic [1:0] cas_b_o;
  logic [1:0] cas_at_rf;
  logic req_ready_o, busy_o, rdata_valid_o, ras_b_o, we_b_o, dq_oe_o;
  int err_count;
  int checks_done;
  real t_acc, t_rf, t_rr, t_cf, t_cr, t_wf, t_oe, t_col, g_ras, g_cas, g_rc;
  logic [15:0] rd_q [$];

  dctg_top i_dctg_top (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .cfg_i(cfg_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .selfref_hold_i(selfref_hold_i),
    .dq_i(dq_i), .req_ready_o(req_ready_o), .busy_o(busy_o), .rdata_o(rdata_o),
    .rdata_valid_o(rdata_valid_o), .ras_b_o(ras_b_o), .cas_b_o(cas_b_o), .we_b_o(we_b_o),
    .ma_o(ma_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
  dctg_dram_model i_dctg_dram_model (.ras_b_i(ras_b_o), .cas_b_i(cas_b_o), .we_b_i(we_b_o),
    .ma_i(ma_o), .wd_i(dq_o), .oe_i(dq_oe_o), .dq_o(dq_i));

  // memory clock, 25 ns
  initial
  begin
    clock_i = 1'b0;
    forever
      #12.5 clock_i = ~clock_i;
  end

  // strobe edge times; gaps are taken at each fall against the last rise
  always @(negedge ras_b_o)
  begin
    t_rf = $realtime;
    g_ras = t_rf - t_rr;
    cas_at_rf = cas_b_o;
  end
  always @(posedge ras_b_o)
    t_rr = $realtime;
  always @(negedge cas_b_o[0])
  begin
    t_cf = $realtime;
    g_cas = t_cf - t_cr;
    g_rc = t_cf - t_rr;
  end
  always @(posedge cas_b_o[0])
    t_cr = $realtime;
  always @(negedge we_b_o)
    t_wf = $realtime;
  always @(posedge dq_oe_o)
    t_oe = $realtime;
  always @(ma_o)
    if (ras_b_o === 1'b0)
      t_col = $realtime;
  // read words taken mid-cycle, where the pulse is settled
  always @(negedge clock_i)
    if (rdata_valid_o === 1'b1)
      rd_q.push_back(rdata_o);

  task automatic chk(input bit ok, input string msg);
    checks_done++;
    if (!ok)
    begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    do
    begin
      @(negedge clock_i);
      n++;
    end
    while (req_ready_o !== 1'b1 && n < lim);
    chk(n < lim, "no ready");
  endtask

  // valid stays up afterwards, so a following call is taken back to back
  task automatic issue(input dctg_pkg::dctg_kind_type k, input int c, input logic [15:0] w);
    req_i <= '{kind: k, row: ~10'(c), col: 10'(c), wdata: w, byte_en: 2'h3};
    req_valid_i <= 1'b1;
    wait_ready(40);
    @(posedge clock_i);
    t_acc = $realtime;
  endtask

  task automatic done;
    req_valid_i <= 1'b0;
    wait_ready(60);
    repeat (3) @(negedge clock_i);
    @(posedge clock_i);
  endtask

  task automatic sc_reset;
    chk(ras_b_o === 1'b1 && cas_b_o === 2'h3 && we_b_o === 1'b1 && dq_oe_o === 1'b0
      && busy_o === 1'b0 && req_ready_o === 1'b0, "reset levels");
  endtask

  task automatic sc_len;
    real t0;
    for (int l = 0; l < 3; l++)
    begin
      cfg_i <= {1'b0, 2'(l), 1'b1, 2'h2};
      @(posedge clock_i);
      issue(dctg_pkg::DCTG_READ, 1, 16'h0);
      t0 = t_acc;
      issue(dctg_pkg::DCTG_READ, 2, 16'h0);
      done();
      chk(t_acc - t0 > (5 - l) * 25.0 - 0.5, "cycle short");
    end
    rd_q.delete();
  endtask

  // write then read back to back in every precharge and delay setting
  task automatic sc_acc;
    real e;
    for (int p = 0; p < 3; p++)
      for (int b = 0; b < 2; b++)
      begin
        cfg_i <= {1'b0, 2'h0, b[0], 2'(p)};
        @(posedge clock_i);
        issue(dctg_pkg::DCTG_WRITE, p * 2 + b, 16'h5a00 + 16'(p * 2 + b));
        issue(dctg_pkg::DCTG_READ, p * 2 + b, 16'h0);
        done();
        e = (p == 1 ? 25.0 : 37.5) + (b ? 0.0 : 25.0);
        chk(t_cf - t_rf > e - 1.0 && t_cf - t_rf < e + 1.0, "rcd");
        chk(g_ras > (p == 0 ? 49.0 : p == 1 ? 35.2 : 24.0), "row precharge");
        chk(t_rf - t_acc > (p == 0 ? 49.9 : p == 1 ? 36.2 : 24.9), "row setup");
        chk(t_col - t_rf > (p == 1 ? 10.2 : 24.0), "row hold");
        e = (p == 1 ? 34.2 : 48.0) + (b ? 0.0 : 25.0);
        chk(t_cr - t_rf > e, "read early");
        chk(rd_q.size() == 1 && rd_q[0] === 16'h5a00 + 16'(p * 2 + b), "rdata");
        rd_q.delete();
      end
  endtask

  task automatic sc_rmw;
    cfg_i <= {1'b0, 2'h0, 1'b1, 2'h0};
    @(posedge clock_i);
    issue(dctg_pkg::DCTG_WRITE, 9, 16'h1234);
    issue(dctg_pkg::DCTG_RMW, 9, 16'habcd);
    issue(dctg_pkg::DCTG_READ, 9, 16'h0);
    done();
    chk(t_oe - t_wf > 11.0 && t_oe - t_wf < 14.0, "driver delay");
    chk(rd_q.size() == 2 && rd_q[0] === 16'h1234 && rd_q[1] === 16'habcd, "rmw");
    rd_q.delete();
  endtask

  // two refreshes back to back, so the second sees the first one's recovery
  task automatic sc_ref;
    for (int e = 0; e < 2; e++)
      for (int p = 0; p < 3; p++)
      begin
        cfg_i <= {e[0], 2'h0, 1'b0, 2'(p)};
        @(posedge clock_i);
        issue(dctg_pkg::DCTG_REFRESH, 0, 16'h0);
        issue(dctg_pkg::DCTG_REFRESH, 0, 16'h0);
        done();
        chk(cas_at_rf === 2'h0 && t_rf - t_cf > 9.2, "column first");
        chk(g_cas > (p == 0 ? 49.9 : 24.9), "column precharge");
        if (e == 0)
        begin
          chk(g_rc > (p == 0 ? 49.9 : 24.9), "row to column");
          chk(g_ras > (p == 0 ? 60.2 : 35.2), "refresh precharge");
        end
        else
        begin
          chk(g_rc > (p == 0 ? 36.2 : 11.2), "row to column");
          chk(t_rf - t_cf > (p == 1 ? 22.9 : 9.2), "column lead");
        end
      end
  endtask

  task automatic sc_self;
    selfref_hold_i <= 1'b1;
    issue(dctg_pkg::DCTG_SELF, 0, 16'h0);
    repeat (12) @(posedge clock_i);
    chk(ras_b_o === 1'b0 && cas_b_o === 2'h0 && busy_o === 1'b1, "self parked");
    selfref_hold_i <= 1'b0;
    done();
    chk(ras_b_o === 1'b1 && cas_b_o === 2'h3, "self exit");
  endtask

  task automatic wrap_up;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // main sequence; reset is held for three edges
  initial
  begin
    err_count = 0;
    checks_done = 0;
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    req_valid_i = 1'b0;
    selfref_hold_i = 1'b0;
    cfg_i = '0;
    req_i = '0;
    repeat (3) @(posedge clock_i);
    sc_reset();
    rst_b_i <= 1'b1;
    done();
    sc_len();
    sc_acc();
    sc_rmw();
    sc_ref();
    sc_self();
    wrap_up();
  end

  // the whole run needs well under 2000 cycles
  initial
  begin
    #200000;
    err_count++;
    wrap_up();
  end
endmodule
